// File: verilog/tpm_top.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module tpm_top
	import tpm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        shutdown_input_n,
	output logic             carrier_irq,
	output tpm_pattern_t     phase_out,
	output tpm_pattern_t     phase_oe_n
);

	////////////////////////////////////////////////////////////////
	logic [7:0]   ctrl0_ff;
	logic [7:0]   ctrl1_ff;
	logic         prot_ff;
	logic [1:0]   spec_ff;
	logic [5:0]   pat0_ff;
	logic [5:0]   pat1_ff;
	logic [7:0]   dtt_ff;
	logic [3:0]   icnt_ff;
	logic [3:0]   idec_ff;
	logic         ifirst_ff;
	logic [15:0]  reload_ff;
	logic [15:0]  width_ff [6];
	logic [2:0]   run_ff;
	logic [15:0]  car_ff;
	tpm_dir_t     dir_ff;
	logic [5:0]   shift0_ff;
	logic [5:0]   shift1_ff;
	logic         use_second_ff;
	logic         half_ff;
	logic         irq_ff;
	logic         wr_ff;
	logic [7:0]   wa_ff;
	logic [31:0]  rdata_ff;

	////////////////////////////////////////////////////////////////
	// bus decode
	logic        acc;
	logic        wr_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_mux;
	assign acc       = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wr_en     = wr_ff;
	assign rd_addr   = haddr[7:0];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	////////////////////////////////////////////////////////////////
	logic        fen;
	logic        saw;
	logic        mode1;
	logic        running;
	logic        underflow;
	logic        xfer;
	logic        cut;
	logic        its_en;
	logic        trix_en;
	logic [15:0] wsel [3];
	logic [2:0]  fall;
	logic [2:0]  startp;
	logic [5:0]  levels;
	logic        car_zero;

	assign fen      = ctrl0_ff[C0_FEN];
	assign saw      = ctrl0_ff[C0_MOD];
	assign mode1    = ctrl1_ff[C1_MODE1];
	assign running  = fen && run_ff[0];
	assign car_zero = (car_ff == 16'h0000);
	// sawtooth wraps every m+1, triangle counts down then up
	assign underflow = running && car_zero && (saw || dir_ff == TPM_DOWN);
	assign xfer = underflow
		|| (wr_en && hit(wa_ff, ADDR_CTRL0) && hwdata[C0_XFER])
		|| (wr_en && hit(wa_ff, ADDR_CARRIER) && ctrl1_ff[C1_RLDW]);
	assign cut     = spec_ff[SP_SDEN] && !shutdown_input_n;
	// interrupt timing bits only in mode 1
	assign its_en  = mode1 && ctrl0_ff[C0_ITCE];
	assign trix_en = mode1 && !saw && ctrl1_ff[C1_TRIX];
	assign levels  = use_second_ff ? shift1_ff : shift0_ff;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ph
			// alternate width in mode 1 on the second half
			assign wsel[g] = (mode1 && half_ff) ? width_ff[g+3] : width_ff[g];
			assign startp[g] = saw ? xfer : (underflow || (trix_en && running && car_zero
				&& dir_ff == TPM_UP));
			tpm_phase u_ph (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.run         (running),
				.start       (startp[g]),
				.width       (wsel[g]),
				.pos_lvl     (levels[5-g]),
				.neg_lvl     (levels[2-g]),
				.dt_trig_sel (ctrl1_ff[C1_DTSEL]),
				.dt_off      (ctrl1_ff[C1_DTDIS]),
				.dt_val      (dtt_ff),
				.falling     (fall[g]),
				.out_pos     (phase_out.pos[2-g]),
				.out_neg     (phase_out.neg[2-g])
			);
		end
	endgenerate

	// float all six pins when output is disabled
	assign phase_oe_n  = (fen && ctrl0_ff[C0_OEN]) ? 6'h00 : 6'h3F;
	assign carrier_irq = irq_ff;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff    <= 1'b0;
			wa_ff    <= 8'h00;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wr_ff <= acc && hwrite;
			wa_ff <= rd_addr;
			if (acc && !hwrite) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (rd_addr)
			ADDR_CTRL0:   rd_mux = {24'h0, ctrl0_ff};
			ADDR_CTRL1:   rd_mux = {24'h0, ctrl1_ff};
			ADDR_PROTECT: rd_mux = {30'h0, prot_ff, 1'b0};
			ADDR_SPECIAL: rd_mux = {30'h0, spec_ff};
			ADDR_PAT0:    rd_mux = {26'h0, pat0_ff};
			ADDR_PAT1:    rd_mux = {26'h0, pat1_ff};
			ADDR_DTT:     rd_mux = {24'h0, dtt_ff};
			ADDR_ICNT:    rd_mux = {28'h0, idec_ff};
			ADDR_CARRIER: rd_mux = {16'h0, reload_ff};
			ADDR_START:   rd_mux = {29'h0, run_ff};
			ADDR_STATUS:  rd_mux = {16'h0, car_ff};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_ff <= RST_CTRL0;
			ctrl1_ff <= RST_CTRL1;
			prot_ff  <= 1'b0;
			spec_ff  <= 2'h0;
			pat0_ff  <= 6'h00;
			pat1_ff  <= 6'h00;
			dtt_ff   <= RST_DTT;
			icnt_ff  <= RST_ICNT;
			reload_ff <= 16'h0000;
			run_ff   <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				width_ff[i] <= RST_WIDTH;
			end
		end else begin
			if (wr_en && hit(wa_ff, ADDR_PROTECT)) prot_ff <= hwdata[PR_REL];
			if (wr_en && hit(wa_ff, ADDR_CTRL0) && prot_ff) ctrl0_ff <= {1'b0, hwdata[6:0]};
			if (wr_en && hit(wa_ff, ADDR_CTRL1) && prot_ff) ctrl1_ff <= hwdata[7:0];
			if (wr_en && hit(wa_ff, ADDR_SPECIAL) && prot_ff) spec_ff <= hwdata[1:0];
			if (wr_en && hit(wa_ff, ADDR_PAT0)) pat0_ff <= hwdata[5:0];
			if (wr_en && hit(wa_ff, ADDR_PAT1)) pat1_ff <= hwdata[5:0];
			if (wr_en && hit(wa_ff, ADDR_DTT)) dtt_ff <= hwdata[7:0];
			if (wr_en && hit(wa_ff, ADDR_ICNT)) icnt_ff <= hwdata[3:0];
			if (wr_en && hit(wa_ff, ADDR_CARRIER)) reload_ff <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_START)) run_ff <= hwdata[2:0];
			if (wr_en && hit(wa_ff, ADDR_WIDTH_U)) width_ff[0] <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_WIDTH_V)) width_ff[1] <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_WIDTH_W)) width_ff[2] <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_ALT_U)) width_ff[3] <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_ALT_V)) width_ff[4] <= hwdata[15:0];
			if (wr_en && hit(wa_ff, ADDR_ALT_W)) width_ff[5] <= hwdata[15:0];
			// cutoff clears output enable, hardware wins
			if (cut) ctrl0_ff[C0_OEN] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// carrier timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			car_ff  <= 16'h0000;
			dir_ff  <= TPM_DOWN;
			half_ff <= 1'b0;
		end else if (!running) begin
			car_ff  <= reload_ff;
			dir_ff  <= TPM_DOWN;
			half_ff <= 1'b0;
		end else if (saw) begin
			car_ff <= car_zero ? reload_ff : car_ff - 16'h0001;
		end else begin
			// triangle: down m..0, up 0..m, each turning point held one count
			case (dir_ff)
				TPM_DOWN: begin
					if (car_zero) begin
						dir_ff  <= TPM_UP;
						half_ff <= 1'b1;
					end else begin
						car_ff <= car_ff - 16'h0001;
					end
				end
				TPM_UP: begin
					if (car_ff >= reload_ff) begin
						dir_ff  <= TPM_DOWN;
						half_ff <= 1'b0;
					end else begin
						car_ff <= car_ff + 16'h0001;
					end
				end
				default: dir_ff <= TPM_DOWN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// output shift register and decimation counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift0_ff     <= 6'h00;
			shift1_ff     <= 6'h00;
			use_second_ff <= 1'b0;
			idec_ff       <= RST_ICNT;
			ifirst_ff     <= 1'b1;
			irq_ff        <= 1'b0;
		end else begin
			irq_ff <= 1'b0;
			// load both buffers, switch on one-shot fall
			if (xfer) begin
				shift0_ff     <= pat0_ff;
				shift1_ff     <= pat1_ff;
				use_second_ff <= 1'b0;
			end else if (|fall) begin
				use_second_ff <= 1'b1;
			end
			if (wr_en && hit(wa_ff, ADDR_ICNT)) begin
				idec_ff   <= hwdata[3:0];
				ifirst_ff <= 1'b1;
			end else if (underflow) begin
				// with ITS set, first after n-1, then every n
				if (idec_ff <= 4'h1 || (its_en && ctrl0_ff[C0_ITS] && ifirst_ff
					&& idec_ff == 4'h2)) begin
					irq_ff    <= 1'b1;
					idec_ff   <= icnt_ff;
					ifirst_ff <= 1'b0;
				end else begin
					idec_ff <= idec_ff - 4'h1;
				end
			end
		end
	end

endmodule

// File: verilog/tpm_pkg.sv
package tpm_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL0   = 8'h00;
	localparam logic [7:0] ADDR_CTRL1   = 8'h04;
	localparam logic [7:0] ADDR_PROTECT = 8'h08;
	localparam logic [7:0] ADDR_SPECIAL = 8'h0C;
	localparam logic [7:0] ADDR_PAT0    = 8'h10;
	localparam logic [7:0] ADDR_PAT1    = 8'h14;
	localparam logic [7:0] ADDR_DTT     = 8'h18;
	localparam logic [7:0] ADDR_ICNT    = 8'h1C;
	localparam logic [7:0] ADDR_CARRIER = 8'h20;
	localparam logic [7:0] ADDR_WIDTH_U = 8'h24;
	localparam logic [7:0] ADDR_WIDTH_V = 8'h28;
	localparam logic [7:0] ADDR_WIDTH_W = 8'h2C;
	localparam logic [7:0] ADDR_ALT_U   = 8'h30;
	localparam logic [7:0] ADDR_ALT_V   = 8'h34;
	localparam logic [7:0] ADDR_ALT_W   = 8'h38;
	localparam logic [7:0] ADDR_START   = 8'h3C;
	localparam logic [7:0] ADDR_STATUS  = 8'h40;

	// control 0 fields
	localparam int C0_ITS   = 0;
	localparam int C0_ITCE  = 1;
	localparam int C0_FEN   = 2;
	localparam int C0_OEN   = 3;
	localparam int C0_MOD   = 6;
	localparam int C0_XFER  = 7;
	// control 1 fields
	localparam int C1_RLDW  = 0;
	localparam int C1_MODE1 = 1;
	localparam int C1_TRIX  = 3;
	localparam int C1_DTDIS = 5;
	localparam int C1_DTSEL = 6;
	// special mode fields
	localparam int SP_RLSEL = 0;
	localparam int SP_SDEN  = 1;
	// protect register
	localparam int PR_REL   = 1;

	localparam logic [7:0]  RST_CTRL0 = 8'h00;
	localparam logic [7:0]  RST_CTRL1 = 8'h00;
	localparam logic [7:0]  RST_DTT   = 8'h01;
	localparam logic [3:0]  RST_ICNT  = 4'h1;
	localparam logic [15:0] RST_WIDTH = 16'h0001;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic u;
		logic v;
		logic w;
	} tpm_phase_t;

	typedef struct packed {
		tpm_phase_t pos;
		tpm_phase_t neg;
	} tpm_pattern_t;

	typedef enum logic {
		TPM_UP,
		TPM_DOWN
	} tpm_dir_t;

endpackage

// File: verilog/tpm_phase.sv
`timescale 1ns/1ns
// one phase: width timer one-shot plus dead time counter
module tpm_phase
	import tpm_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        run,
	input  wire logic        start,
	input  wire logic [15:0] width,
	input  wire logic        pos_lvl,
	input  wire logic        neg_lvl,
	input  wire logic        dt_trig_sel,
	input  wire logic        dt_off,
	input  wire logic [7:0]  dt_val,
	output logic             falling,
	output logic             out_pos,
	output logic             out_neg
);

	logic [15:0] cnt_ff;
	logic        shot_ff;
	logic [7:0]  dt_ff;
	logic        pos_d_ff;
	logic        neg_d_ff;
	logic        pos_ff;
	logic        neg_ff;
	logic        dt_busy;
	logic        edge_trig;
	logic        pat_rise;
	logic [7:0]  dt_load;

	assign falling   = shot_ff && (cnt_ff == 16'h0001);
	assign dt_busy   = (dt_ff != 8'h00);
	assign pat_rise  = (pos_lvl && !pos_d_ff) || (neg_lvl && !neg_d_ff);
	assign edge_trig = dt_trig_sel ? pat_rise : (falling || start);
	// pattern rise is seen a cycle late, so count one less
	assign dt_load   = dt_trig_sel ? dt_val - 8'h01 : dt_val;
	assign out_pos   = pos_ff;
	assign out_neg   = neg_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff  <= 16'h0000;
			shot_ff <= 1'b0;
		end else if (!run) begin
			shot_ff <= 1'b0;
		end else if (start) begin
			cnt_ff  <= width;
			shot_ff <= (width != 16'h0000);
		end else if (shot_ff) begin
			cnt_ff  <= cnt_ff - 16'h0001;
			shot_ff <= !falling;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dt_ff    <= 8'h00;
			pos_d_ff <= 1'b0;
			neg_d_ff <= 1'b0;
			pos_ff   <= 1'b0;
			neg_ff   <= 1'b0;
		end else begin
			pos_d_ff <= pos_lvl;
			neg_d_ff <= neg_lvl;
			if (!run || dt_off) begin
				dt_ff <= 8'h00;
			end else if (edge_trig) begin
				dt_ff <= dt_load;
			end else if (dt_busy) begin
				dt_ff <= dt_ff - 8'h01;
			end
			// outputs rise only after dead time expires, a lit output stays lit
			pos_ff <= pos_lvl && (pos_ff || dt_off || (!dt_busy && !edge_trig))
				&& !(pos_lvl && neg_lvl);
			neg_ff <= neg_lvl && (neg_ff || dt_off || (!dt_busy && !edge_trig))
				&& !(pos_lvl && neg_lvl);
		end
	end

endmodule

// File: dv/tpm_top_properties.sv
`timescale 1ns/1ns
module tpm_top_chk
	import tpm_pkg::*;
(
	input wire logic         hclk,
	input wire logic         hresetn,
	input wire logic         hsel,
	input wire logic [31:0]  haddr,
	input wire logic [1:0]   htrans,
	input wire logic         hwrite,
	input wire logic [31:0]  hwdata,
	input wire logic         hready,
	input wire logic [31:0]  hrdata,
	input wire logic         hreadyout,
	input wire logic         hresp,
	input wire logic         shutdown_input_n,
	input wire logic         carrier_irq,
	input wire tpm_pattern_t phase_out,
	input wire tpm_pattern_t phase_oe_n
);
	logic        tk_ff;
	logic        wr_ff;
	logic [7:0]  ad_ff;
	logic        prot_ff;
	logic        sden_ff;
	logic        fen_ff;
	logic [15:0] car_ff;
	wire         take = hsel & hready & (htrans == HTRANS_NONSEQ);
	wire         wdat = tk_ff & wr_ff;
	wire         rdat = tk_ff & ~wr_ff;
	// shadow of the software-visible control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tk_ff <= 1'b0;
			wr_ff <= 1'b0;
			ad_ff <= 8'h00;
			prot_ff <= 1'b0;
			sden_ff <= 1'b0;
			fen_ff <= 1'b0;
			car_ff <= 16'h0000;
		end else begin
			tk_ff <= take;
			wr_ff <= hwrite;
			ad_ff <= haddr[7:0];
			if (wdat && ad_ff == ADDR_PROTECT) prot_ff <= hwdata[PR_REL];
			if (wdat && prot_ff && ad_ff == ADDR_SPECIAL) sden_ff <= hwdata[SP_SDEN];
			if (wdat && prot_ff && ad_ff == ADDR_CTRL0) fen_ff <= hwdata[C0_FEN];
			if (wdat && ad_ff == ADDR_CARRIER) car_ff <= hwdata[15:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus response not okay");
	a_unmapped_reads_zero: assert property (rdat && ad_ff > ADDR_STATUS |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_read_data_holds: assert property (!rdat |-> $stable(hrdata))
		else $error("read data moved without a read");
	a_reset_quiet: assert property ($rose(hresetn) |-> phase_oe_n == 6'h3F && !carrier_irq)
		else $error("outputs active right after reset");
	a_cutoff_floats_pins: assert property (sden_ff && !shutdown_input_n |-> ##[1:3] phase_oe_n == 6'h3F)
		else $error("pins not floated on shutdown");
	a_disabled_pins_float: assert property ((!fen_ff) [*3] |-> phase_oe_n == 6'h3F)
		else $error("pins driven with function off");
	a_disabled_no_irq: assert property ((!fen_ff) [*3] |-> !carrier_irq)
		else $error("interrupt with function off");
	a_irq_single_pulse: assert property (carrier_irq && car_ff != 16'h0 |=> !carrier_irq)
		else $error("interrupt wider than one cycle");
	c_irq: cover property (carrier_irq);
	c_cutoff: cover property (sden_ff && !shutdown_input_n);
	c_read: cover property (rdat);
endmodule
bind tpm_top tpm_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .shutdown_input_n(shutdown_input_n),
	.carrier_irq(carrier_irq), .phase_out(phase_out), .phase_oe_n(phase_oe_n));

// File: dv/tpm_gate_model.sv
`timescale 1ns/1ns
module tpm_gate_model
	import tpm_pkg::*;
(
	input  wire logic         trip,
	input  wire tpm_pattern_t phase_out,
	input  wire tpm_pattern_t phase_oe_n,
	output logic [2:0]        gate_pos,
	output logic [2:0]        gate_neg,
	output logic              shutdown_input_n
);
	// floated pin falls to driver pull-down
	assign gate_pos = phase_out.pos & ~phase_oe_n.pos;
	assign gate_neg = phase_out.neg & ~phase_oe_n.neg;
	// shutdown pin, returned high on release
	assign shutdown_input_n = ~trip;
endmodule

// File: dv/three_phase_motor_pwm_control_bench.sv
`timescale 1ns/1ns
module three_phase_motor_pwm_control_bench
	import tpm_pkg::*;
;
	logic         hclk, hresetn, hsel, hwrite, trip, hreadyout, hresp, carrier_irq, sd_n;
	logic [31:0]  haddr, hwdata, hrdata, q;
	logic [1:0]   htrans;
	logic [2:0]   hsize, gate_pos, gate_neg;
	tpm_pattern_t phase_out, phase_oe_n;
	int           errors, num_checks, n;
	tpm_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .shutdown_input_n(sd_n),
		.carrier_irq(carrier_irq), .phase_out(phase_out), .phase_oe_n(phase_oe_n));
	tpm_gate_model u_gate (.trip(trip), .phase_out(phase_out), .phase_oe_n(phase_oe_n),
		.gate_pos(gate_pos), .gate_neg(gate_neg), .shutdown_input_n(sd_n));
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(s, e, q & m);
	endtask
	// cycles between two interrupt pulses
	task automatic irq_gap();
		n = 0;
		while (carrier_irq !== 1'b1 && n < 900) begin
			@(posedge hclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (carrier_irq !== 1'b1 && n < 900);
	endtask
	// cycles from u high side off to u low side on
	task automatic dt_gap();
		n = 0;
		while (gate_pos[2] !== 1'b1 && n < 900) begin
			@(posedge hclk);
			n++;
		end
		while (gate_pos[2] === 1'b1 && n < 1800) begin
			@(posedge hclk);
			n++;
		end
		n = 0;
		while (gate_neg[2] !== 1'b1 && n < 300) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		#(20000 * 50);
		errors++;
		report_and_stop;
	end
	initial begin
		{hsel, hwrite, trip, hresetn, errors, num_checks} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("ctrl0 reset", ADDR_CTRL0, 32'hFF, {24'h0, RST_CTRL0});
		rdc("ctrl1 reset", ADDR_CTRL1, 32'hFF, {24'h0, RST_CTRL1});
		rdc("dtt reset", ADDR_DTT, 32'hFF, {24'h0, RST_DTT});
		rdc("icnt reset", ADDR_ICNT, 32'hF, {28'h0, RST_ICNT});
		rdc("special reset", ADDR_SPECIAL, 32'h3, 32'h0);
		rdc("unmapped", 8'h44, 32'hFFFFFFFF, 32'h0);
		xfer(1'b1, ADDR_CTRL0, 32'h04);
		rdc("ctrl0 locked", ADDR_CTRL0, 32'hFF, 32'h0);
		xfer(1'b1, ADDR_PROTECT, 32'h2);
		xfer(1'b1, ADDR_CTRL1, 32'h0);
		xfer(1'b1, ADDR_CARRIER, 32'h4);
		xfer(1'b1, ADDR_ICNT, 32'h2);
		xfer(1'b1, ADDR_CTRL0, 32'h04);
		xfer(1'b1, ADDR_START, 32'h1);
		irq_gap();
		chk("triangle irq gap", 32'd20, n);
		xfer(1'b1, ADDR_START, 32'h0);
		xfer(1'b1, ADDR_CTRL0, 32'h44);
		xfer(1'b1, ADDR_START, 32'h1);
		irq_gap();
		chk("sawtooth irq gap", 32'd10, n);
		xfer(1'b1, ADDR_START, 32'h0);
		xfer(1'b1, ADDR_CTRL0, 32'h04);
		xfer(1'b1, ADDR_CTRL1, 32'h02);
		xfer(1'b1, ADDR_ICNT, 32'h3);
		xfer(1'b1, ADDR_CTRL0, 32'h07);
		xfer(1'b1, ADDR_START, 32'h1);
		n = 0;
		while (carrier_irq !== 1'b1 && n < 900) begin
			@(posedge hclk);
			n++;
		end
		chk("first irq early", 32'h1, {31'h0, n > 10 && n < 21});
		irq_gap();
		chk("decimated irq gap", 32'd30, n);
		xfer(1'b1, ADDR_START, 32'h0);
		xfer(1'b1, ADDR_CTRL0, 32'h0C);
		xfer(1'b1, ADDR_CTRL1, 32'h00);
		xfer(1'b1, ADDR_CARRIER, 32'd40);
		xfer(1'b1, ADDR_WIDTH_U, 32'd20);
		xfer(1'b1, ADDR_WIDTH_V, 32'd20);
		xfer(1'b1, ADDR_WIDTH_W, 32'd20);
		xfer(1'b1, ADDR_DTT, 32'h5);
		xfer(1'b1, ADDR_PAT0, 32'h38);
		xfer(1'b1, ADDR_PAT1, 32'h07);
		xfer(1'b1, ADDR_CTRL0, 32'h8C);
		xfer(1'b1, ADDR_START, 32'h1);
		dt_gap();
		chk("dead time", 32'd5, n);
		xfer(1'b1, ADDR_START, 32'h0);
		xfer(1'b1, ADDR_CTRL1, 32'h20);
		xfer(1'b1, ADDR_START, 32'h1);
		dt_gap();
		chk("no dead time", 32'd0, n);
		xfer(1'b1, ADDR_START, 32'h0);
		xfer(1'b1, ADDR_CTRL1, 32'h40);
		xfer(1'b1, ADDR_START, 32'h1);
		dt_gap();
		chk("edge dead time", 32'd5, n);
		xfer(1'b1, ADDR_SPECIAL, 32'h2);
		trip <= 1'b1;
		repeat (4) @(posedge hclk);
		chk("pins floated", 32'h3F, {26'h0, phase_oe_n});
		rdc("output enable", ADDR_CTRL0, 32'h08, 32'h0);
		trip <= 1'b0;
		xfer(1'b1, ADDR_SPECIAL, 32'h0);
		xfer(1'b1, ADDR_CTRL0, 32'h0C);
		repeat (3) @(posedge hclk);
		chk("pins driven", 32'h0, {26'h0, phase_oe_n});
		report_and_stop;
	end
endmodule
